// >>> pkg/mcfi_pkg.sv
// constants and types for the motion command frame interpreter
package mcfi_pkg;
    // frame geometry
    localparam int CORE_LEN = 7;
    localparam int SER_LEN = 9;
    localparam logic [3:0] LAST_SER = 4'h8;
    localparam logic [3:0] LAST_CORE = 4'h6;
    // status codes
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_STORED = 8'h65;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    localparam logic [7:0] ST_LOCKED = 8'h05;
    localparam logic [7:0] ST_NOT_AVAIL = 8'h06;
    // command codes
    localparam logic [7:0] CMD_ROTATE_RIGHT = 8'h01;
    localparam logic [7:0] CMD_ROTATE_LEFT = 8'h02;
    localparam logic [7:0] CMD_MOTOR_STOP = 8'h03;
    localparam logic [7:0] CMD_MOVE_TO_POSITION = 8'h04;
    localparam logic [7:0] CMD_SET_AXIS_PARAM = 8'h05;
    localparam logic [7:0] CMD_GET_AXIS_PARAM = 8'h06;
    localparam logic [7:0] CMD_SET_GLOBAL_PARAM = 8'h09;
    localparam logic [7:0] CMD_GET_GLOBAL_PARAM = 8'h0A;
    localparam logic [7:0] CMD_STORE_GLOBAL_PARAM = 8'h0B;
    localparam logic [7:0] CMD_RESTORE_GLOBAL_PARAM = 8'h0C;
    localparam logic [7:0] CMD_REFERENCE_SEARCH = 8'h0D;
    localparam logic [7:0] CMD_GET_INPUT = 8'h0F;
    localparam logic [7:0] CMD_ACCUMULATOR_ARITH = 8'h13;
    localparam logic [7:0] CMD_COMPARE = 8'h14;
    localparam logic [7:0] CMD_CONDITIONAL_JUMP = 8'h15;
    localparam logic [7:0] CMD_ABSOLUTE_JUMP = 8'h16;
    localparam logic [7:0] CMD_SUBROUTINE_CALL = 8'h17;
    localparam logic [7:0] CMD_SUBROUTINE_RETURN = 8'h18;
    localparam logic [7:0] CMD_INTERRUPT_ENABLE = 8'h19;
    localparam logic [7:0] CMD_INTERRUPT_DISABLE = 8'h1A;
    localparam logic [7:0] CMD_WAIT = 8'h1B;
    localparam logic [7:0] CMD_PROGRAM_END = 8'h1C;
    // move_to_position targeting types
    localparam logic [7:0] MVP_ABS = 8'h00;
    localparam logic [7:0] MVP_REL = 8'h01;
    localparam logic [7:0] MVP_COORD = 8'h02;
    // reference_search types
    localparam logic [7:0] RFS_START = 8'h00;
    localparam logic [7:0] RFS_STOP = 8'h01;
    localparam logic [7:0] RFS_STATUS = 8'h02;

    typedef enum logic [1:0] {
        MCFI_RX = 2'b00,
        MCFI_EXEC = 2'b01,
        MCFI_WAIT = 2'b11,
        MCFI_TX = 2'b10
    } mcfi_state_t;

    typedef struct packed {
        mcfi_state_t st;
        logic [3:0] idx;
        logic [7:0] sum;
        logic [7:0] addr;
        logic [7:0] cmd;
        logic [7:0] typ;
        logic [7:0] bank;
        logic [31:0] val;
        logic [7:0] status;
        logic [31:0] rval;
        logic sum_bad;
        logic exec_vld;
        logic tx_vld;
        logic [7:0] tx_data;
        logic tx_last;
        logic tx_en;
    } mcfi_regs_t;
endpackage

// >>> core/mcfi_interp.sv
// command frame receiver, decoder and reply sender
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RULE_01) core: command, type, bank, value MSB-first
// (RULE_02) serial frame adds address and checksum byte
// (RULE_03) command checksum sums all preceding bytes
// (RULE_04) exactly one reply per received command; a serial frame whose address is not module_addr_i gets no reply
// (RULE_05) serial reply: reply addr, addr, status, cmd, value, sum
// (RULE_06) reply checksum sums all other bytes
// (RULE_07) host waits for reply before next command
// (RULE_08) status 100 executed, 101 stored
// (RULE_09) error statuses one to six
// (RULE_10) CAN command carries core only
// (RULE_11) CAN reply omits address and checksum
// (RULE_12) codes 1,2,3 rotate right, left, stop
// (RULE_13) code 4 move, abs/rel/coord type
// (RULE_14) codes 5,6,9,10 axis and global params
// (RULE_15) codes 11,12 on user variables only
// (RULE_16) code 13 reference search, 15 get input
// (RULE_17) codes 19 to 24 program flow
// (RULE_18) codes 25 to 28 interrupts, wait, end
// (RULE_19) transmit only as reply, never unsolicited
// (RULE_20) bad checksum not executed; unknown code invalid
//////////////////////////////////////////////////////////////////////////////
module mcfi_interp
    import mcfi_pkg::*;
#(
    parameter logic [7:0] USER_BANK = 8'h02,
    parameter logic [7:0] NUM_MOTORS = 8'h01
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic can_mode_i,
    input wire logic [7:0] module_addr_i,
    input wire logic [7:0] reply_addr_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    output logic tx_enable_o,
    input wire logic store_mode_i,
    input wire logic cfg_locked_i,
    output logic exec_valid_o,
    output logic [7:0] exec_cmd_o,
    output logic [7:0] exec_type_o,
    output logic [7:0] exec_bank_o,
    output logic [31:0] exec_value_o,
    input wire logic exec_done_i,
    input wire logic [7:0] exec_status_i,
    input wire logic [31:0] exec_result_i
);
    mcfi_regs_t r_reg;
    mcfi_regs_t r_next;

    // command classification
    function automatic logic known_cmd(input logic [7:0] c);
        unique case (c)
            CMD_ROTATE_RIGHT, CMD_ROTATE_LEFT, CMD_MOTOR_STOP,         // RULE_12
            CMD_MOVE_TO_POSITION,                                      // RULE_13
            CMD_SET_AXIS_PARAM, CMD_GET_AXIS_PARAM,
            CMD_SET_GLOBAL_PARAM, CMD_GET_GLOBAL_PARAM,                // RULE_14
            CMD_STORE_GLOBAL_PARAM, CMD_RESTORE_GLOBAL_PARAM,          // RULE_15
            CMD_REFERENCE_SEARCH, CMD_GET_INPUT,                       // RULE_16
            CMD_ACCUMULATOR_ARITH, CMD_COMPARE, CMD_CONDITIONAL_JUMP,
            CMD_ABSOLUTE_JUMP, CMD_SUBROUTINE_CALL,
            CMD_SUBROUTINE_RETURN,                                     // RULE_17
            CMD_INTERRUPT_ENABLE, CMD_INTERRUPT_DISABLE,
            CMD_WAIT, CMD_PROGRAM_END: known_cmd = 1'b1;               // RULE_18
            default: known_cmd = 1'b0;
        endcase
    endfunction

    // program-flow commands only make sense inside a stored program
    function automatic logic flow_cmd(input logic [7:0] c);
        flow_cmd = (c >= CMD_ACCUMULATOR_ARITH) && (c <= CMD_PROGRAM_END);
    endfunction

    // static pre-check of command, type and bank fields; 0 means pass on to the executor, or store when store_mode_i is set
    function automatic logic [7:0] precheck(input logic [7:0] c, input logic [7:0] t,
                                            input logic [7:0] b);
        precheck = 8'h00;
        if (!known_cmd(c))
            precheck = ST_BAD_CMD;                                     // RULE_20
        else if (c == CMD_MOVE_TO_POSITION && t > MVP_COORD)
            precheck = ST_BAD_TYPE;                                    // RULE_13
        else if (c == CMD_REFERENCE_SEARCH && t > RFS_STATUS)
            precheck = ST_BAD_TYPE;                                    // RULE_16
        else if ((c == CMD_STORE_GLOBAL_PARAM || c == CMD_RESTORE_GLOBAL_PARAM)
                 && b != USER_BANK)
            precheck = ST_BAD_VALUE;                                   // RULE_15
        else if ((c == CMD_SET_GLOBAL_PARAM || c == CMD_STORE_GLOBAL_PARAM) && cfg_locked_i)
            precheck = ST_LOCKED;                                      // RULE_09
        else if (c <= CMD_GET_AXIS_PARAM && c != CMD_MOVE_TO_POSITION && b >= NUM_MOTORS)
            precheck = ST_BAD_VALUE;                                   // RULE_12
        else if (flow_cmd(c) && !store_mode_i)
            precheck = ST_NOT_AVAIL;                                   // RULE_17
    endfunction

    // reply byte by position; serial frames have 9, CAN frames 7 (module address first)
    function automatic logic [7:0] reply_byte(input mcfi_regs_t s, input logic [3:0] i,
                                              input logic [7:0] ra, input logic [7:0] ma);
        unique case (i)
            4'h0: reply_byte = ra;
            4'h1: reply_byte = ma;
            4'h2: reply_byte = s.status;
            4'h3: reply_byte = s.cmd;
            4'h4: reply_byte = s.rval[31:24];
            4'h5: reply_byte = s.rval[23:16];
            4'h6: reply_byte = s.rval[15:8];
            4'h7: reply_byte = s.rval[7:0];
            default: reply_byte = s.sum;
        endcase
    endfunction

    logic [7:0] pc;
    logic [3:0] ser_pos;
    logic [7:0] rbyte;

    always_comb begin
        r_next = r_reg;
        r_next.exec_vld = 1'b0;
        pc = precheck(r_reg.cmd, r_reg.typ, r_reg.bank);
        // CAN frames map onto serial positions 1..7 with no address or checksum
        ser_pos = can_mode_i ? r_reg.idx + 4'h1 : r_reg.idx;               // RULE_10
        rbyte = 8'h00;
        unique case (r_reg.st)
            MCFI_RX: begin
                r_next.tx_en = 1'b0;                                      // RULE_19
                if (rx_valid_i) begin
                    r_next.sum = r_reg.sum + rx_data_i;                   // RULE_03
                    r_next.idx = r_reg.idx + 4'h1;
                    unique case (ser_pos)
                        4'h0: r_next.addr = rx_data_i;                    // RULE_02
                        4'h1: r_next.cmd = rx_data_i;                     // RULE_01
                        4'h2: r_next.typ = rx_data_i;
                        4'h3: r_next.bank = rx_data_i;
                        4'h4, 4'h5, 4'h6, 4'h7:
                            r_next.val = {r_reg.val[23:0], rx_data_i};    // RULE_01
                        default: r_next.sum_bad = (rx_data_i != r_reg.sum); // RULE_03
                    endcase
                    if (r_reg.idx == (can_mode_i ? LAST_CORE : LAST_SER)) begin
                        r_next.idx = 4'h0;
                        r_next.st = MCFI_EXEC;
                    end
                end
            end
            MCFI_EXEC: begin
                r_next.rval = r_reg.val;
                // frames addressed elsewhere get no reply on a shared bus
                if (!can_mode_i && r_reg.addr != module_addr_i) begin
                    r_next.sum = 8'h00;
                    r_next.sum_bad = 1'b0;
                    r_next.st = MCFI_RX;                                  // RULE_19
                end else if (!can_mode_i && r_reg.sum_bad) begin
                    r_next.status = ST_BAD_SUM;                           // RULE_20
                    r_next.st = MCFI_TX;
                end else if (pc != 8'h00) begin
                    r_next.status = pc;                                   // RULE_09
                    r_next.st = MCFI_TX;
                end else if (store_mode_i) begin
                    r_next.status = ST_STORED;                            // RULE_08
                    r_next.st = MCFI_TX;
                end else begin
                    r_next.exec_vld = 1'b1;
                    r_next.st = MCFI_WAIT;
                end
                r_next.sum = 8'h00;
                // the CAN identifier stands in for the reply address byte only
                r_next.idx = can_mode_i ? 4'h1 : 4'h0;                    // RULE_11
            end
            MCFI_WAIT: begin
                if (exec_done_i) begin
                    r_next.status = (exec_status_i == 8'h00) ? ST_OK : exec_status_i; // RULE_08
                    r_next.rval = exec_result_i;
                    r_next.st = MCFI_TX;
                end
            end
            MCFI_TX: begin
                r_next.tx_en = 1'b1;
                if (!r_reg.tx_vld || tx_ready_i) begin
                    if (r_reg.tx_vld && r_reg.tx_last) begin
                        r_next.tx_vld = 1'b0;
                        r_next.tx_last = 1'b0;
                        r_next.tx_en = 1'b0;
                        r_next.idx = 4'h0;
                        r_next.sum = 8'h00;
                        r_next.sum_bad = 1'b0;
                        r_next.st = MCFI_RX;                              // RULE_04
                    end else begin
                        rbyte = reply_byte(r_reg, r_reg.idx, reply_addr_i, module_addr_i);
                        r_next.tx_data = rbyte;                           // RULE_05
                        r_next.tx_vld = 1'b1;
                        r_next.sum = r_reg.sum + rbyte;                   // RULE_06
                        r_next.idx = r_reg.idx + 4'h1;
                        r_next.tx_last = can_mode_i ? (r_reg.idx == 4'h7) // RULE_11
                                                    : (r_reg.idx == LAST_SER);
                    end
                end
            end
            default: r_next.st = MCFI_RX;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tx_valid_o = r_reg.tx_vld;
    assign tx_data_o = r_reg.tx_data;
    assign tx_last_o = r_reg.tx_last;
    assign tx_enable_o = r_reg.tx_en;
    assign exec_valid_o = r_reg.exec_vld;
    assign exec_cmd_o = r_reg.cmd;
    assign exec_type_o = r_reg.typ;
    assign exec_bank_o = r_reg.bank;
    assign exec_value_o = r_reg.val;

    //////////////////////////////////////////////////////////////////////////
    sequence s_ser_frame_end;
        r_reg.st == MCFI_RX && rx_valid_i && !can_mode_i && r_reg.idx == LAST_SER;
    endsequence

    property p_frame_to_exec;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_ser_frame_end |=> r_reg.st == MCFI_EXEC;
    endproperty
    a_frame_to_exec: assert property (p_frame_to_exec) else $error("frame end missed"); // RULE_02

    property p_bad_sum_no_exec;
        @(posedge clk_i) disable iff (sys_rst_i)
        (r_reg.st == MCFI_EXEC && !can_mode_i && r_reg.sum_bad && r_reg.addr == module_addr_i)
        |=> !exec_valid_o && r_reg.st == MCFI_TX && r_reg.status == ST_BAD_SUM;
    endproperty
    a_bad_sum_no_exec: assert property (p_bad_sum_no_exec) else $error("bad sum executed"); // RULE_20

    property p_tx_only_reply;
        @(posedge clk_i) disable iff (sys_rst_i)
        tx_valid_o |-> r_reg.st == MCFI_TX && tx_enable_o;
    endproperty
    a_tx_only_reply: assert property (p_tx_only_reply) else $error("unsolicited transmit"); // RULE_19

    property p_reply_ends;
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_valid_o && tx_last_o && tx_ready_i) |=> r_reg.st == MCFI_RX && !tx_valid_o;
    endproperty
    a_reply_ends: assert property (p_reply_ends) else $error("reply not closed"); // RULE_04

    property p_sum_byte;
        @(posedge clk_i) disable iff (sys_rst_i)
        (r_reg.st == MCFI_TX && !can_mode_i && (!tx_valid_o || tx_ready_i) && r_reg.idx == LAST_SER)
        |=> tx_data_o == $past(r_reg.sum) && tx_last_o;
    endproperty
    a_sum_byte: assert property (p_sum_byte) else $error("reply checksum wrong"); // RULE_06

    property p_done_ok;
        @(posedge clk_i) disable iff (sys_rst_i)
        (r_reg.st == MCFI_WAIT && exec_done_i && exec_status_i == 8'h00) |=> r_reg.status == ST_OK;
    endproperty
    a_done_ok: assert property (p_done_ok) else $error("ok status wrong"); // RULE_08

    property p_unknown_cmd;
        @(posedge clk_i) disable iff (sys_rst_i)
        (r_reg.st == MCFI_EXEC && (can_mode_i || (r_reg.addr == module_addr_i && !r_reg.sum_bad))
         && !known_cmd(r_reg.cmd)) |=> r_reg.status == ST_BAD_CMD;
    endproperty
    a_unknown_cmd: assert property (p_unknown_cmd) else $error("invalid code accepted"); // RULE_09

    property p_can_first;
        @(posedge clk_i) disable iff (sys_rst_i)
        (r_reg.st == MCFI_EXEC && can_mode_i) |=> r_reg.idx == 4'h1;
    endproperty
    a_can_first: assert property (p_can_first) else $error("can reply start wrong"); // RULE_11

    // a frame that reaches the decision step for this module
    sequence s_frame_taken;
        r_reg.st == MCFI_EXEC && (can_mode_i || (r_reg.addr == module_addr_i && !r_reg.sum_bad));
    endsequence

    property p_stored_no_exec;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_frame_taken ##0 (pc == 8'h00 && store_mode_i)
        |=> !exec_valid_o && r_reg.st == MCFI_TX && r_reg.status == ST_STORED;
    endproperty
    a_stored_no_exec: assert property (p_stored_no_exec) else $error("stored cmd run"); // RULE_08

    property p_exec_pulse;
        @(posedge clk_i) disable iff (sys_rst_i)
        exec_valid_o |=> !exec_valid_o && r_reg.st == MCFI_WAIT;
    endproperty
    a_exec_pulse: assert property (p_exec_pulse) else $error("exec not single"); // RULE_04

    // a shared bus must stay quiet for frames meant for another node
    property p_drop_foreign;
        @(posedge clk_i) disable iff (sys_rst_i)
        (r_reg.st == MCFI_EXEC && !can_mode_i && r_reg.addr != module_addr_i)
        |=> r_reg.st == MCFI_RX && !tx_enable_o;
    endproperty
    a_drop_foreign: assert property (p_drop_foreign) else $error("foreign frame answered"); // RULE_19

    property p_byte_holds;
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
    endproperty
    a_byte_holds: assert property (p_byte_holds) else $error("reply byte dropped"); // RULE_05
endmodule

// >>> verification/mcfi_host.sv
// host-side model: sends command frames and collects reply bytes
module mcfi_host
    import mcfi_pkg::*;
(
    input wire logic clk_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic tx_ready_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rq[$];
    logic got_last;
    int last_pos;
    logic slow;

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'hFF;
        tx_ready_o = 1'b1;
        got_last = 1'b0;
        last_pos = -1;
        slow = 1'b0;
    end

    // a slow sink toggles ready, so every reply byte must stand while refused
    always @(posedge clk_i) begin
        tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
        if (tx_valid_i && tx_ready_o) begin
            if (tx_last_i) begin
                last_pos = rq.size();
                got_last = 1'b1;
            end
            rq.push_back(tx_data_i);
        end
    end

    task automatic send_cmd(input logic can, input logic [7:0] addr, input logic [7:0] cmd,
            input logic [7:0] typ, input logic [7:0] bank, input logic [31:0] val,
            input logic bad_sum);
        logic [7:0] f[$];
        logic [7:0] s;
        rq.delete();
        got_last = 1'b0;
        last_pos = -1;
        f = {cmd, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0]};
        if (!can) begin
            f.push_front(addr);
            s = 8'h00;
            foreach (f[i]) s = s + f[i];
            f.push_back(bad_sum ? s + 8'h01 : s);
        end
        foreach (f[i]) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= f[i];
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        // idle data line must not keep showing the last byte
        rx_data_o <= ~f[f.size()-1];
    endtask
endmodule

// >>> verification/tb_mcfi_interp.sv
// self-checking bench for the command frame interpreter
module tb_mcfi_interp
    import mcfi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
        $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
    localparam logic [7:0] MOD_ADDR = 8'h05;
    localparam logic [7:0] RPL_ADDR = 8'h02;
    localparam logic [31:0] CMD_VAL = 32'h89ABCDEF;
    localparam logic [31:0] RES_VAL = 32'hA5C30F96;
    logic clk_i, sys_rst_i, can_mode, store_mode, cfg_locked, rx_valid, tx_ready;
    logic tx_valid, tx_last, tx_enable, exec_valid, exec_done;
    logic [7:0] rx_data, tx_data, exec_cmd, exec_type, exec_bank, exec_status, ex_st;
    logic [31:0] exec_value, exec_result;
    int ex_cnt, n_exec, num_errors, compares;

    mcfi_interp mcfi_interp_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .can_mode_i(can_mode),
        .module_addr_i(MOD_ADDR), .reply_addr_i(RPL_ADDR), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_last_o(tx_last), .tx_enable_o(tx_enable), .store_mode_i(store_mode),
        .cfg_locked_i(cfg_locked), .exec_valid_o(exec_valid), .exec_cmd_o(exec_cmd),
        .exec_type_o(exec_type), .exec_bank_o(exec_bank), .exec_value_o(exec_value),
        .exec_done_i(exec_done), .exec_status_i(exec_status), .exec_result_i(exec_result));
    mcfi_host mcfi_host_i (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .tx_ready_o(tx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // executor stand-in answers four cycles after each hand-over
    always @(posedge clk_i) begin
        exec_done <= 1'b0;
        if (exec_valid) begin
            n_exec++;
            ex_cnt <= 3;
        end else if (ex_cnt != 0) begin
            ex_cnt <= ex_cnt - 1;
            if (ex_cnt == 1) begin
                exec_done <= 1'b1;
                exec_status <= ex_st;
                exec_result <= RES_VAL;
            end
        end
    end

    always @(posedge clk_i) begin
        if (tx_valid === 1'b1 && tx_enable !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: byte sent with driver off", $time);
        end
    end

    task automatic end_sim();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic run_cmd(input logic [7:0] cmd, input logic [7:0] typ, input logic [7:0] bank,
            input logic bad, input logic [7:0] st, input logic do_exec);
        int n0;
        int k;
        logic [7:0] s;
        n0 = n_exec;
        mcfi_host_i.send_cmd(can_mode, MOD_ADDR, cmd, typ, bank, CMD_VAL, bad);
        for (k = 0; k < 300 && mcfi_host_i.got_last !== 1'b1; k++) @(posedge clk_i);
        if (mcfi_host_i.got_last !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: reply missing", $time);
            end_sim();
        end
        k = can_mode ? 1 : 2;
        `CHK(mcfi_host_i.rq.size(), can_mode ? 7 : 9)
        `CHK(mcfi_host_i.last_pos, can_mode ? 6 : 8)
        `CHK(mcfi_host_i.rq[k-1], MOD_ADDR)
        `CHK(mcfi_host_i.rq[k], st)
        `CHK(mcfi_host_i.rq[k+1], cmd)
        `CHK(n_exec - n0, do_exec ? 1 : 0)
        if (do_exec) begin
            `CHK({mcfi_host_i.rq[k+2], mcfi_host_i.rq[k+3], mcfi_host_i.rq[k+4],
                mcfi_host_i.rq[k+5]}, RES_VAL)
            `CHK({exec_cmd, exec_type, exec_bank, exec_value}, {cmd, typ, bank, CMD_VAL})
        end
        if (!can_mode) begin
            `CHK(mcfi_host_i.rq[0], RPL_ADDR)
            s = 8'h00;
            for (int i = 0; i < 8; i++) s = s + mcfi_host_i.rq[i];
            `CHK(mcfi_host_i.rq[8], s)
        end
    endtask

    task automatic t_reset();
        repeat (10) @(posedge clk_i);
        `CHK({tx_valid, tx_enable, exec_valid}, 3'b000)
        sys_rst_i <= 1'b0;
        $display("test reset done");
    endtask

    task automatic t_decode();
        logic [7:0] c[12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0A,
            8'h0B, 8'h0C, 8'h0D, 8'h0F};
        mcfi_host_i.slow <= 1'b1;
        foreach (c[i]) run_cmd(c[i], 8'h00, (c[i] inside {8'h0B, 8'h0C}) ? 8'h02 : 8'h00,
            1'b0, ST_OK, 1'b1);
        for (int t = 1; t < 3; t++) begin
            run_cmd(CMD_MOVE_TO_POSITION, t[7:0], 8'h00, 1'b0, ST_OK, 1'b1);
            run_cmd(CMD_REFERENCE_SEARCH, t[7:0], 8'h00, 1'b0, ST_OK, 1'b1);
        end
        mcfi_host_i.slow <= 1'b0;
        $display("test decode done");
    endtask

    task automatic t_stored();
        store_mode <= 1'b1;
        for (int c = 19; c < 29; c++) run_cmd(c[7:0], 8'h00, 8'h00, 1'b0, ST_STORED, 1'b0);
        run_cmd(CMD_ROTATE_RIGHT, 8'h00, 8'h00, 1'b0, ST_STORED, 1'b0);
        store_mode <= 1'b0;
        $display("test stored done");
    endtask

    task automatic t_errors();
        run_cmd(CMD_GET_AXIS_PARAM, 8'h00, 8'h00, 1'b1, ST_BAD_SUM, 1'b0);
        run_cmd(8'h07, 8'h00, 8'h00, 1'b0, ST_BAD_CMD, 1'b0);
        run_cmd(CMD_MOVE_TO_POSITION, 8'h03, 8'h00, 1'b0, ST_BAD_TYPE, 1'b0);
        run_cmd(CMD_REFERENCE_SEARCH, 8'h03, 8'h00, 1'b0, ST_BAD_TYPE, 1'b0);
        run_cmd(CMD_ROTATE_LEFT, 8'h00, 8'h01, 1'b0, ST_BAD_VALUE, 1'b0);
        run_cmd(CMD_STORE_GLOBAL_PARAM, 8'h00, 8'h01, 1'b0, ST_BAD_VALUE, 1'b0);
        run_cmd(CMD_CONDITIONAL_JUMP, 8'h00, 8'h00, 1'b0, ST_NOT_AVAIL, 1'b0);
        cfg_locked <= 1'b1;
        run_cmd(CMD_SET_GLOBAL_PARAM, 8'h00, 8'h00, 1'b0, ST_LOCKED, 1'b0);
        run_cmd(CMD_STORE_GLOBAL_PARAM, 8'h00, 8'h02, 1'b0, ST_LOCKED, 1'b0);
        cfg_locked <= 1'b0;
        ex_st = 8'h04;
        run_cmd(CMD_SET_AXIS_PARAM, 8'h00, 8'h00, 1'b0, ST_BAD_VALUE, 1'b1);
        ex_st = 8'h00;
        $display("test errors done");
    endtask

    task automatic t_can();
        can_mode <= 1'b1;
        @(posedge clk_i);
        run_cmd(CMD_GET_AXIS_PARAM, 8'h01, 8'h00, 1'b0, ST_OK, 1'b1);
        run_cmd(8'h08, 8'h00, 8'h00, 1'b0, ST_BAD_CMD, 1'b0);
        can_mode <= 1'b0;
        @(posedge clk_i);
        $display("test can done");
    endtask

    task automatic t_wrong_addr();
        int n0;
        n0 = n_exec;
        mcfi_host_i.send_cmd(1'b0, 8'h06, CMD_MOTOR_STOP, 8'h00, 8'h00, CMD_VAL, 1'b0);
        repeat (40) @(posedge clk_i);
        `CHK(mcfi_host_i.rq.size(), 0)
        `CHK(n_exec - n0, 0)
        $display("test wrong address done");
    endtask

    initial begin
        sys_rst_i = 1'b1;
        {can_mode, store_mode, cfg_locked} = 3'h0;
        ex_st = 8'h00;
        t_reset();
        t_decode();
        t_stored();
        t_wrong_addr();
        t_errors();
        t_can();
        end_sim();
    end
endmodule
